/* bench/test_tagged_load_store_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// ========================================
// bench
module test_tagged_load_store_decode;
    logic        sys_clk, reset, issueValid, issueReady, memRdReq, memWrReq, memRdValid;
    logic        rdOldspace, rdEphemeral, rdTransportEn, destWrite, trapValid;
    logic [39:0] instrWord, src1Word, src2Word, memWrWord, memRdWord, destData;
    logic [37:0] longImm;
    logic [31:0] marData, memAddr, r;
    logic [1:0]  rdDelay, trapCode;
    logic [42:0] rdAnswer;
    logic [63:0] a, b, c, d;
    logic [2:0]  fmts [8] = '{3'h5, 3'h6, 3'h7, 3'h5, 3'h6, 3'h7, 3'h6, 3'h2};
    logic [5:0]  opcs [16] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h06, 6'h07, 6'h03, 6'h05,
                               6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1F, 6'h2A};
    logic [5:0]  tags [8] = '{6'h01, 6'h08, 6'h10, 6'h20, 6'h2F, 6'h30, 6'h34, 6'h00};
    int          comparisons, miscompares, seed;

    tlsd_decode dut (.sys_clk(sys_clk), .reset(reset), .issueValid(issueValid),
        .issueReady(issueReady), .instrWord(instrWord), .longImm(longImm), .src1Word(src1Word),
        .src2Word(src2Word), .marData(marData), .memRdReq(memRdReq), .memWrReq(memWrReq),
        .memAddr(memAddr), .memWrWord(memWrWord), .memRdValid(memRdValid),
        .memRdWord(memRdWord), .rdOldspace(rdOldspace), .rdEphemeral(rdEphemeral),
        .rdTransportEn(rdTransportEn), .destWrite(destWrite), .destData(destData),
        .trapValid(trapValid), .trapCode(trapCode));
    tlsd_mem_model partner (.sys_clk(sys_clk), .reset(reset), .memRdReq(memRdReq),
        .stall(rdDelay), .answer(rdAnswer), .memRdValid(memRdValid), .memRdWord(memRdWord),
        .rdOldspace(rdOldspace), .rdEphemeral(rdEphemeral), .rdTransportEn(rdTransportEn));

    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // one instruction: expectation, issue, wait for the outcome
    task automatic run_op(input logic [39:0] ins, input logic [39:0] s1, input logic [39:0] s2,
                          input logic [42:0] ans);
        logic [63:0] li;
        logic [31:0] mar, eaddr;
        logic [39:0] w, expDest, expWr;
        logic [5:0]  opc;
        logic [2:0]  fmt;
        logic [1:0]  expTrap;
        logic        ld, st, ptr, sawRd, expRd, isDest;
        li = {$random(seed), $random(seed)};
        mar = $random(seed);
        fmt = ins[39:37];
        opc = ins[34:29];
        w = ans[42:3];
        ld = opc[5:3] == 3'h0 && opc != 6'h03 && opc != 6'h05;
        st = opc[5:3] == 3'h3;
        ptr = tlsd_pkg::POINTER_TAG_MAP[w[37:32]];
        eaddr = s1[31:0] + (fmt == 3'h5 ? li[31:0] : fmt == 3'h7 ?
                {{20{ins[11]}}, ins[11:0]} : ld ? s2[31:0] : mar);
        expWr = opc[2:0] <= 3'h5 ? {w[39:38], s2[37:0]} : s2;
        expDest = w;
        expTrap = 2'h0;
        expRd = 1'b0;
        isDest = 1'b0;
        if (!(fmt inside {3'h5, 3'h6, 3'h7}) || !(ld || st)) expTrap = 2'h2;
        else if (s1[37:32] != {1'b0, ins[16:12]} || ld && fmt == 3'h6 && s2[37:32] != 6'h08)
            expTrap = 2'h1;
        else begin
            expRd = 1'b1;
            if (st) ;
            else if (opc == 6'h07 && ans[2] && ans[0] && ptr) expTrap = 2'h3;
            else if (opc inside {6'h04, 6'h06, 6'h07} && w[37:32] == 6'h01) expTrap = 2'h2;
            else begin
                isDest = 1'b1;
                if (opc == 6'h01 && !(ans[2] && ptr) || opc == 6'h00 && !(ans[1] && ptr))
                    expDest = tlsd_pkg::NIL_WORD;
            end
        end
        @(posedge sys_clk);
        issueValid <= 1'b1;
        instrWord  <= ins;
        src1Word   <= s1;
        src2Word   <= s2;
        longImm    <= li[37:0];
        marData    <= mar;
        rdAnswer   <= ans;
        rdDelay    <= 2'($random(seed));
        @(posedge sys_clk);
        issueValid <= 1'b0;
        sawRd = 1'b0;
        for (int i = 0; i < 20; i++) begin
            #1;
            if (memRdReq) begin
                sawRd = 1'b1;
                `CHECK(memAddr, eaddr)
                `CHECK(issueReady, 1'b0)
            end
            if (trapValid || destWrite || memWrReq) break;
            @(posedge sys_clk);
        end
        `CHECK({sawRd, trapValid, destWrite, memWrReq}, {expRd, expTrap != 2'h0, isDest, st && expRd})
        `CHECK(issueReady, 1'b1)
        if (expTrap != 2'h0) `CHECK(trapCode, expTrap)
        if (isDest) `CHECK(destData, expDest)
        if (st && expRd) `CHECK(memWrWord, expWr)
    endtask : run_op

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // about 400 operations of under 10 cycles each
    initial begin
        #200000;
        miscompares++;
        finish_test;
    end

    initial begin
        seed = 32'hD841;
        comparisons = 0;
        miscompares = 0;
        reset = 1'b1;
        issueValid = 1'b0;
        instrWord = 40'h0;
        src1Word = 40'h0;
        src2Word = 40'h0;
        longImm = 38'h0;
        marData = 32'h0;
        rdDelay = 2'h0;
        rdAnswer = 43'h0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        run_op({3'h7, 2'h0, 6'h02, 12'h0, 5'h08, 12'h800}, {8'h08, 32'h100}, 40'h0,
               {40'hC0_2F00_0000, 3'h7});
        run_op({3'h6, 2'h0, 6'h07, 12'h0, 5'h10, 12'h0}, {8'h50, 32'h10}, {8'h08, 32'hFFFF_FFF0},
               {40'h20_0000_1234, 3'h5});
        for (int n = 0; n < 400; n++) begin
            r = $random(seed);
            a = {$random(seed), $random(seed)};
            b = {$random(seed), $random(seed)};
            c = {$random(seed), $random(seed)};
            d = {$random(seed), $random(seed)};
            a[39:37] = fmts[r[2:0]];
            a[34:29] = opcs[r[6:3]];
            b[37:32] = r[9:7] != 3'h0 ? {1'b0, a[16:12]} : tags[r[12:10]];
            c[37:32] = r[14:13] != 2'h0 ? 6'h08 : tags[r[12:10]];
            d[37:32] = tags[r[17:15]];
            run_op(a[39:0], b[39:0], c[39:0], {d[39:0], r[20:18]});
        end
        finish_test;
    end
endmodule : test_tagged_load_store_decode
`default_nettype wire

/* bench/tlsd_decode_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ========================================
// port checker
module tlsd_decode_monitor (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        issueValid,
    input wire logic        issueReady,
    input wire logic [39:0] instrWord,
    input wire logic [37:0] longImm,
    input wire logic [39:0] src1Word,
    input wire logic [39:0] src2Word,
    input wire logic [31:0] marData,
    input wire logic        memRdReq,
    input wire logic        memWrReq,
    input wire logic [31:0] memAddr,
    input wire logic [39:0] memWrWord,
    input wire logic        memRdValid,
    input wire logic [39:0] memRdWord,
    input wire logic        rdOldspace,
    input wire logic        rdEphemeral,
    input wire logic        rdTransportEn,
    input wire logic        destWrite,
    input wire logic [39:0] destData,
    input wire logic        trapValid,
    input wire logic [1:0]  trapCode
);
    logic [5:0]  op_q;
    logic        store_q;
    logic [39:0] src2_q;
    wire logic [2:0]  fmt    = instrWord[39:37];
    wire logic [5:0]  opc    = instrWord[34:29];
    wire logic        take   = issueValid && issueReady;
    wire logic        fmtOk  = fmt == 3'h5 || fmt[2:1] == 2'h3;
    wire logic        ldOk   = opc[5:3] == 3'h0 && opc != 6'h03 && opc != 6'h05;
    wire logic        stOk   = opc[5:3] == 3'h3;
    wire logic        s1Ok   = src1Word[37:32] == {1'b0, instrWord[16:12]};
    wire logic [31:0] sImm   = {{20{instrWord[11]}}, instrWord[11:0]};
    wire logic [31:0] eAddr  = src1Word[31:0] + (fmt == 3'h5 ? longImm[31:0] :
                               fmt == 3'h7 ? sImm : ldOk ? src2Word[31:0] : marData);
    wire logic        rdBack = memRdValid && !issueReady && !memRdReq;
    wire logic        ptr    = tlsd_pkg::POINTER_TAG_MAP[memRdWord[37:32]];
    wire logic        xport  = rdOldspace && rdTransportEn && ptr;
    wire logic        isCopy = op_q == 6'h07 || op_q == 6'h06 || op_q == 6'h04;
    wire logic        fwd    = memRdWord[37:32] == 6'h01 && isCopy;
    wire logic [39:0] merged = op_q[2:0] <= 3'h5 ? {memRdWord[39:38], src2_q[37:0]} : src2_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            op_q    <= 6'h00;
            store_q <= 1'b0;
            src2_q  <= 40'h00_0000_0000;
        end else if (take) begin
            op_q    <= opc;
            store_q <= stOk;
            src2_q  <= src2Word;
        end
    end

    sequence s_read_back(logic [5:0] op);
        rdBack && !store_q && op_q == op;
    endsequence

    a_issue_answer: assert property (take |=> trapValid || memRdReq)
        else $error("issue left without answer");
    a_type_trap: assert property (take && fmtOk && (ldOk || stOk) && !s1Ok |=> trapValid && trapCode == 2'h1 && !memRdReq)
        else $error("source tag mismatch not trapped");
    a_fixnum_trap: assert property (take && fmt == 3'h6 && ldOk && s1Ok && src2Word[37:32] != 6'h08 |=> trapValid && trapCode == 2'h1)
        else $error("reg-reg source2 tag not trapped");
    a_mem_addr: assert property (take && fmtOk && s1Ok && (stOk || ldOk && (fmt != 3'h6 || src2Word[37:32] == 6'h08)) |=> memRdReq && memAddr == $past(eAddr))
        else $error("wrong effective address");
    a_scav_transport: assert property (s_read_back(6'h07) ##0 xport |=> trapValid && trapCode == 2'h3)
        else $error("scavenge transport trap missing");
    a_forward_err: assert property (rdBack && !store_q && fwd && !xport |=> trapValid && trapCode == 2'h2)
        else $error("forward tag not trapped");
    a_plain_dest: assert property (rdBack && !store_q && (op_q == 6'h02 || isCopy && op_q != 6'h07 && !fwd) |=> destWrite && !trapValid && destData == $past(memRdWord))
        else $error("raw or copy read result wrong");
    a_oldspace_nil: assert property (s_read_back(6'h01) ##0 !(rdOldspace && ptr) |=> destWrite && destData == tlsd_pkg::NIL_WORD)
        else $error("oldspace test did not give nil");
    a_ephemeral_nil: assert property (s_read_back(6'h00) ##0 !(rdEphemeral && ptr) |=> destWrite && destData == tlsd_pkg::NIL_WORD)
        else $error("ephemeral test did not give nil");
    a_store_merge: assert property (rdBack && store_q |=> memWrReq && memWrWord == $past(merged) && $stable(memAddr))
        else $error("store word or address wrong");
    a_trap_quiet: assert property (trapValid |-> !destWrite && !memWrReq)
        else $error("trap with update");
endmodule : tlsd_decode_monitor

bind tlsd_decode tlsd_decode_monitor u_monitor (.*);
`default_nettype wire

/* bench/tlsd_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ========================================
// memory path, answers reads after a stall
module tlsd_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        memRdReq,
    input  wire logic [1:0]  stall,
    input  wire logic [42:0] answer,
    output logic             memRdValid,
    output logic      [39:0] memRdWord,
    output logic             rdOldspace,
    output logic             rdEphemeral,
    output logic             rdTransportEn
);
    logic [1:0]       count_q;
    logic             busy_q;
    wire logic        fire = busy_q && count_q == 2'h0;
    wire logic [42:0] held = {memRdWord, rdOldspace, rdEphemeral, rdTransportEn};
    // outside a delivery the lines toggle, so the last delivered word shows again every other cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_q     <= 1'b0;
            count_q    <= 2'h0;
            memRdValid <= 1'b0;
            {memRdWord, rdOldspace, rdEphemeral, rdTransportEn} <= 43'h0;
        end else begin
            busy_q     <= memRdReq || (busy_q && !fire);
            count_q    <= memRdReq ? stall : count_q - 2'h1;
            memRdValid <= fire;
            {memRdWord, rdOldspace, rdEphemeral, rdTransportEn} <= fire ? answer : ~held;
        end
    end
endmodule : tlsd_mem_model
`default_nettype wire

/* core/tlsd_addr_gen.sv */
package tlsd_pkg;

    // ==========================================================
    // word layout
    localparam int WORD_W   = 40;
    localparam int ADDR_W   = 32;
    localparam int TAG_W    = 6;
    localparam int CDR_HI   = 39;
    localparam int CDR_LO   = 38;
    localparam int TAG_HI   = 37;
    localparam int TAG_LO   = 32;
    localparam int DATA_HI  = 31;
    localparam int LIMM_W   = 38;

    // ==========================================================
    // instruction fields
    localparam int FMT_HI   = 39;
    localparam int FMT_LO   = 37;
    localparam int OPC_HI   = 34;
    localparam int OPC_LO   = 29;
    localparam int TYPE_HI  = 16;
    localparam int TYPE_LO  = 12;
    localparam int IMM_HI   = 11;
    localparam int SIMM_W   = 12;

    localparam logic [2:0] FMT_REG_REG   = 3'h6;
    localparam logic [2:0] FMT_SHORT_IMM = 3'h7;
    localparam logic [2:0] FMT_LONG_IMM  = 3'h5;

    // ==========================================================
    // opcodes
    localparam logic [5:0] OP_EPHEMERAL_TEST = 6'h00;
    localparam logic [5:0] OP_OLDSPACE_TEST  = 6'h01;
    localparam logic [5:0] OP_RAW_READ       = 6'h02;
    localparam logic [5:0] OP_COPY_READ_ALT  = 6'h04;
    localparam logic [5:0] OP_COPY_READ      = 6'h06;
    localparam logic [5:0] OP_SCAVENGE_READ  = 6'h07;
    localparam logic [2:0] OP_LOAD_GROUP     = 3'h0;
    localparam logic [2:0] OP_STORE_GROUP    = 3'h3;
    localparam logic [5:0] OP_STORE_ARRAY    = 6'h18;
    localparam logic [5:0] OP_STORE_BIND     = 6'h19;
    localparam logic [5:0] OP_STORE_DATA     = 6'h1A;
    localparam logic [5:0] OP_STORE_DATA_IV  = 6'h1B;
    localparam logic [5:0] OP_STORE_38_BITS  = 6'h1C;
    localparam logic [5:0] OP_STORE_RPLACD   = 6'h1D;

    // ==========================================================
    // tags
    localparam logic [5:0]  TAG_FIXNUM            = 6'h08;
    localparam logic [5:0]  TAG_NIL               = 6'h34;
    localparam logic [5:0]  TAG_COLLECTOR_FORWARD = 6'h01;
    localparam logic [63:0] POINTER_TAG_MAP       = 64'h0000_FFFF_FFFF_0000;
    localparam logic [39:0] NIL_WORD              = 40'h34_0000_0000;

    typedef enum logic [1:0] {
        TLSD_TRAP_NONE      = 2'b00,
        TLSD_TRAP_SRC_TYPE  = 2'b01,
        TLSD_TRAP_ERROR     = 2'b10,
        TLSD_TRAP_TRANSPORT = 2'b11
    } tlsd_trap_t;

    typedef enum logic [0:0] {
        TLSD_IDLE = 1'b0,
        TLSD_WAIT = 1'b1
    } tlsd_state_t;

    function automatic logic isPointer(input logic [5:0] tag);
        return POINTER_TAG_MAP[tag];
    endfunction : isPointer

    function automatic logic typeMatch(input logic [5:0] tag, input logic [4:0] typ);
        return tag == {1'b0, typ};
    endfunction : typeMatch

    function automatic logic isCopyRead(input logic [5:0] opc);
        return (opc == OP_COPY_READ) || (opc == OP_COPY_READ_ALT);
    endfunction : isCopyRead

endpackage : tlsd_pkg

`timescale 1ns/10ps
`default_nettype none

module tlsd_addr_gen (
    input  wire logic [2:0]  fmtCode,
    input  wire logic        isStore,
    input  wire logic [31:0] src1Data,
    input  wire logic [31:0] src2Data,
    input  wire logic [31:0] marData,
    input  wire logic [11:0] shortImm,
    input  wire logic [37:0] longImm,
    output logic      [31:0] effAddr
);
    // ==========================================================
    // effective address
    wire logic [31:0] regRegTerm = isStore ? marData : src2Data;
    wire logic [31:0] shortTerm  = {{20{shortImm[11]}}, shortImm};
    wire logic [31:0] longTerm   = longImm[31:0];

    assign effAddr = (fmtCode == tlsd_pkg::FMT_REG_REG)   ? src1Data + regRegTerm :
                     (fmtCode == tlsd_pkg::FMT_SHORT_IMM) ? src1Data + shortTerm :
                                                            longTerm + src1Data;

endmodule : tlsd_addr_gen

`default_nettype wire

/* core/tlsd_decode.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - load address is src1+src2, src1+signed imm12, or imm38+src1 by format.
// - loads check src1 tag against type; reg-reg also wants fixnum src2.
// - scavenge read errors on a collector-forward word.
// - scavenge read transport-traps on oldspace pointer when page enables it.
// - copy read errors on collector-forward word, no other read trap.
// - raw read returns word unchanged, never traps on it.
// - oldspace test returns word if oldspace pointer, else NIL.
// - ephemeral test returns word if ephemeral pointer, else NIL.
// - store address is src1+mar in reg-reg, src1+immediate otherwise.
// - store data is the src2 operand.
// - stores check src1 tag against type and trap on mismatch.
// - data, iv, array, rplacd, bind, 38-bit stores keep target cdr bits.
// - format in bits 39:37; opcode 34, src1 28, src2 22, type 16, imm 11.
// - transport trap wins over any other trap on the word read.
module tlsd_decode (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        issueValid,
    output logic             issueReady,
    input  wire logic [39:0] instrWord,
    input  wire logic [37:0] longImm,
    input  wire logic [39:0] src1Word,
    input  wire logic [39:0] src2Word,
    input  wire logic [31:0] marData,
    output logic             memRdReq,
    output logic             memWrReq,
    output logic      [31:0] memAddr,
    output logic      [39:0] memWrWord,
    input  wire logic        memRdValid,
    input  wire logic [39:0] memRdWord,
    input  wire logic        rdOldspace,
    input  wire logic        rdEphemeral,
    input  wire logic        rdTransportEn,
    output logic             destWrite,
    output logic      [39:0] destData,
    output logic             trapValid,
    output logic      [1:0]  trapCode
);
    // ==========================================================
    // instruction fields
    wire logic [2:0]  fmtField  = instrWord[tlsd_pkg::FMT_HI:tlsd_pkg::FMT_LO];
    wire logic [5:0]  opcField  = instrWord[tlsd_pkg::OPC_HI:tlsd_pkg::OPC_LO];
    wire logic [4:0]  typeField = instrWord[tlsd_pkg::TYPE_HI:tlsd_pkg::TYPE_LO];
    wire logic [11:0] shortImm  = instrWord[tlsd_pkg::IMM_HI:0];

    wire logic isRegReg = fmtField == tlsd_pkg::FMT_REG_REG;
    wire logic fmtOk    = isRegReg || (fmtField == tlsd_pkg::FMT_SHORT_IMM)
                          || (fmtField == tlsd_pkg::FMT_LONG_IMM);
    wire logic opIsStore = opcField[5:3] == tlsd_pkg::OP_STORE_GROUP;
    wire logic opIsLoad  = (opcField == tlsd_pkg::OP_EPHEMERAL_TEST)
                           || (opcField == tlsd_pkg::OP_OLDSPACE_TEST)
                           || (opcField == tlsd_pkg::OP_RAW_READ)
                           || tlsd_pkg::isCopyRead(opcField)
                           || (opcField == tlsd_pkg::OP_SCAVENGE_READ);
    wire logic legal     = fmtOk && (opIsStore || opIsLoad);

    // ==========================================================
    // source checks
    wire logic [5:0] src1Tag = src1Word[tlsd_pkg::TAG_HI:tlsd_pkg::TAG_LO];
    wire logic [5:0] src2Tag = src2Word[tlsd_pkg::TAG_HI:tlsd_pkg::TAG_LO];
    wire logic src1Ok  = tlsd_pkg::typeMatch(src1Tag, typeField);
    wire logic src2Ok  = opIsStore || !isRegReg || (src2Tag == tlsd_pkg::TAG_FIXNUM);
    wire logic srcOk   = src1Ok && src2Ok;

    wire logic [31:0] genAddr;

    tlsd_addr_gen u_addr (
        .fmtCode  (fmtField),
        .isStore  (opIsStore),
        .src1Data (src1Word[tlsd_pkg::DATA_HI:0]),
        .src2Data (src2Word[tlsd_pkg::DATA_HI:0]),
        .marData  (marData),
        .shortImm (shortImm),
        .longImm  (longImm),
        .effAddr  (genAddr)
    );

    // ==========================================================
    // state
    tlsd_pkg::tlsd_state_t state_q;
    logic [5:0]  opc_q;
    logic        isStore_q;
    logic [39:0] storeData_q;
    logic        memRdReq_q;
    logic        memWrReq_q;
    logic [31:0] memAddr_q;
    logic [39:0] memWrWord_q;
    logic        destWrite_q;
    logic [39:0] destData_q;
    logic        trapValid_q;
    logic [1:0]  trapCode_q;

    wire logic issueTaken = issueValid && (state_q == tlsd_pkg::TLSD_IDLE);
    wire logic readDone   = memRdValid && (state_q == tlsd_pkg::TLSD_WAIT);

    // ==========================================================
    // word read classification
    wire logic [5:0] rdTag = memRdWord[tlsd_pkg::TAG_HI:tlsd_pkg::TAG_LO];
    wire logic rdPtr = tlsd_pkg::isPointer(rdTag);
    wire logic rdOld = rdPtr && rdOldspace;
    wire logic rdEph = rdPtr && rdEphemeral;
    wire logic rdFwd = rdTag == tlsd_pkg::TAG_COLLECTOR_FORWARD;
    wire logic isScav = opc_q == tlsd_pkg::OP_SCAVENGE_READ;
    wire logic isCopy = tlsd_pkg::isCopyRead(opc_q);

    wire logic scavTransport = isScav && rdOld && rdTransportEn;
    wire logic fwdError      = (isScav || isCopy) && rdFwd;
    wire logic rdTrap        = !isStore_q && (scavTransport || fwdError);
    wire logic [1:0] rdTrapCode = scavTransport ? tlsd_pkg::TLSD_TRAP_TRANSPORT
                                                : tlsd_pkg::TLSD_TRAP_ERROR;

    wire logic nilOld = (opc_q == tlsd_pkg::OP_OLDSPACE_TEST) && !rdOld;
    wire logic nilEph = (opc_q == tlsd_pkg::OP_EPHEMERAL_TEST) && !rdEph;
    wire logic [39:0] loadWord = (nilOld || nilEph) ? tlsd_pkg::NIL_WORD : memRdWord;

    wire logic keepCdr = (opc_q == tlsd_pkg::OP_STORE_DATA)
                         || (opc_q == tlsd_pkg::OP_STORE_DATA_IV)
                         || (opc_q == tlsd_pkg::OP_STORE_ARRAY)
                         || (opc_q == tlsd_pkg::OP_STORE_RPLACD)
                         || (opc_q == tlsd_pkg::OP_STORE_BIND)
                         || (opc_q == tlsd_pkg::OP_STORE_38_BITS);
    wire logic [39:0] mergedWord = keepCdr
        ? {memRdWord[tlsd_pkg::CDR_HI:tlsd_pkg::CDR_LO], storeData_q[tlsd_pkg::TAG_HI:0]}
        : storeData_q;

    // ==========================================================
    // sequencing
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q     <= tlsd_pkg::TLSD_IDLE;
            opc_q       <= 6'h00;
            isStore_q   <= 1'b0;
            storeData_q <= 40'h00_0000_0000;
            memRdReq_q  <= 1'b0;
            memWrReq_q  <= 1'b0;
            memAddr_q   <= 32'h0000_0000;
            memWrWord_q <= 40'h00_0000_0000;
            destWrite_q <= 1'b0;
            destData_q  <= 40'h00_0000_0000;
            trapValid_q <= 1'b0;
            trapCode_q  <= tlsd_pkg::TLSD_TRAP_NONE;
        end else begin
            memRdReq_q  <= 1'b0;
            memWrReq_q  <= 1'b0;
            destWrite_q <= 1'b0;
            trapValid_q <= 1'b0;
            case (state_q)
                tlsd_pkg::TLSD_IDLE: begin
                    if (issueTaken) begin
                        opc_q       <= opcField;
                        isStore_q   <= opIsStore;
                        storeData_q <= src2Word;
                        if (!legal) begin
                            trapValid_q <= 1'b1;
                            trapCode_q  <= tlsd_pkg::TLSD_TRAP_ERROR;
                        end else if (!srcOk) begin
                            trapValid_q <= 1'b1;
                            trapCode_q  <= tlsd_pkg::TLSD_TRAP_SRC_TYPE;
                        end else begin
                            memRdReq_q <= 1'b1;
                            memAddr_q  <= genAddr;
                            state_q    <= tlsd_pkg::TLSD_WAIT;
                        end
                    end
                end
                tlsd_pkg::TLSD_WAIT: begin
                    if (readDone) begin
                        state_q <= tlsd_pkg::TLSD_IDLE;
                        if (isStore_q) begin
                            memWrReq_q  <= 1'b1;
                            memWrWord_q <= mergedWord;
                        end else if (rdTrap) begin
                            trapValid_q <= 1'b1;
                            trapCode_q  <= rdTrapCode;
                        end else begin
                            destWrite_q <= 1'b1;
                            destData_q  <= loadWord;
                        end
                    end
                end
                default: begin
                    state_q <= tlsd_pkg::TLSD_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign issueReady = state_q == tlsd_pkg::TLSD_IDLE;
    assign memRdReq   = memRdReq_q;
    assign memWrReq   = memWrReq_q;
    assign memAddr    = memAddr_q;
    assign memWrWord  = memWrWord_q;
    assign destWrite  = destWrite_q;
    assign destData   = destData_q;
    assign trapValid  = trapValid_q;
    assign trapCode   = trapCode_q;

endmodule : tlsd_decode

`default_nettype wire
